// ==== core/async_serial_transceiver.sv ====
// asynchronous serial transceiver with axi4-lite register slave
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
module async_serial_transceiver (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write
  input  wire logic [serial_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // axi4-lite read
  input  wire logic [serial_pkg::ADDR_W-1:0] araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // interrupt requests and vector acknowledge
  output logic                           rx_done_irq,
  output logic                           tx_done_irq,
  output logic                           tx_empty_irq,
  input  wire logic                      tx_done_ack,
  // output pin and its port settings
  input  wire logic                      line_out_port_val,
  input  wire logic                      line_out_dir_bit,
  output logic                           line_out_o,
  output logic                           line_out_oe_n,
  // input pin and its port settings
  input  wire logic                      line_in_i,
  input  wire logic                      line_in_dir_bit,
  input  wire logic                      line_in_pullup_bit,
  output logic                           line_in_oe_n,
  output logic                           line_in_pullup_en
);
  import serial_pkg::*;

  // majority of three samples, used for start, data and stop
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : maj3

  // ****************************************
  // register bus slave
  // ****************************************
  ctrl_t                 ctrl_reg;
  logic [7:0]            divider_reg;
  logic [7:0]            tx_hold_reg;
  logic [7:0]            rx_data_reg;
  logic                  rx_done_reg;
  logic                  tx_done_reg;
  logic                  empty_reg;
  logic                  frame_reg;
  logic                  ovr_pend_reg;
  logic                  ovr_vis_reg;
  logic [ADDR_W-1:0]     aw_reg;
  logic                  aw_have_reg;
  logic [7:0]            w_reg;
  logic                  w_lane_reg;
  logic                  w_have_reg;
  logic                  wr_go;
  logic                  wr_data;
  logic                  rd_data;
  logic                  rd_go;
  logic [7:0]            rd_byte;
  logic                  rd_hit;
  logic [7:0]            status_val;

  assign awready = ~aw_have_reg & ~bvalid;
  assign wready  = ~w_have_reg & ~bvalid;
  assign arready = ~rvalid;
  assign wr_go   = aw_have_reg & w_have_reg & ~bvalid;
  assign rd_go   = arvalid & arready;
  // one address, two registers: write path vs read path
  assign wr_data = wr_go & w_lane_reg & (aw_reg == {IDX_DATA[ADDR_W-3:0], 2'b00});
  assign rd_data = rd_go & (araddr == {IDX_DATA[ADDR_W-3:0], 2'b00});

  // address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_reg      <= '0;
      w_reg       <= 8'h00;
      w_lane_reg  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_reg      <= awaddr;
        aw_have_reg <= 1'b1;
      end else if (wr_go) begin
        aw_have_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        w_reg      <= wdata[7:0];
        w_lane_reg <= wstrb[0];
        w_have_reg <= 1'b1;
      end else if (wr_go) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= (aw_reg[1:0] == 2'b00 &&
                 aw_reg[ADDR_W-1:2] >= IDX_DIVIDER[ADDR_W-3:0] &&
                 aw_reg[ADDR_W-1:2] <= IDX_DATA[ADDR_W-3:0]) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // status view; the low three bits read zero
  assign status_val = {rx_done_reg, tx_done_reg, empty_reg, frame_reg, ovr_vis_reg, 3'b000};

  // read decode
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = araddr[1:0] == 2'b00;
    case (araddr[ADDR_W-1:2])
      IDX_DIVIDER[ADDR_W-3:0]: rd_byte = divider_reg;
      IDX_CONTROL[ADDR_W-3:0]: rd_byte = {ctrl_reg[7:1], 1'b0}; // transmit ninth bit is write only
      IDX_STATUS[ADDR_W-3:0]:  rd_byte = status_val;
      IDX_DATA[ADDR_W-3:0]:    rd_byte = rx_data_reg;
      default:                 rd_hit  = 1'b0;
    endcase
  end

  // read answer registered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata  <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************
  // baud generation
  // ****************************************
  logic [7:0] pre_reg;
  logic       tick16;
  logic [3:0] tx_phase_reg;
  logic       bit_tick;
  logic       tx_load;

  // clock over divider plus one gives sixteen ticks per bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg <= 8'h00;
    end else if (pre_reg >= divider_reg) begin
      pre_reg <= 8'h00;
    end else begin
      pre_reg <= pre_reg + 8'h01;
    end
  end
  assign tick16 = pre_reg >= divider_reg;

  // transmit bit clock, restarted by a load so the start bit is whole
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_phase_reg <= 4'h0;
    end else if (tx_load || tick16) begin
      tx_phase_reg <= (tx_load || tx_phase_reg == OVERSAMPLE) ? 4'h0 : tx_phase_reg + 4'h1;
    end
  end
  assign bit_tick = tick16 && tx_phase_reg == OVERSAMPLE;

  // ****************************************
  // control and divider registers
  // ****************************************
  logic       rx_finish;
  logic       ovr_now;
  logic [8:0] rx_sh_reg;

  // software fields; received ninth bit is loaded by hardware
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg    <= ctrl_t'(CONTROL_RST);
      divider_reg <= DIVIDER_RST;
    end else begin
      if (wr_go && w_lane_reg && aw_reg == {IDX_CONTROL[ADDR_W-3:0], 2'b00}) begin
        ctrl_reg[7:2]             <= w_reg[7:2];
        ctrl_reg.tx_ninth_bit     <= w_reg[C_TX_B8]; // set before the data write
      end
      if (wr_go && w_lane_reg && aw_reg == {IDX_DIVIDER[ADDR_W-3:0], 2'b00}) begin
        divider_reg <= w_reg;
      end
      if (rx_finish && !ovr_now && ctrl_reg.nine_bit_select) begin
        ctrl_reg.rx_ninth_bit <= rx_sh_reg[8];
      end
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  logic [10:0] tx_sh_reg;
  logic [3:0]  tx_cnt_reg;
  logic        tx_busy_reg;
  logic        tx_full_reg;
  logic        tx_active;
  logic        tx_end;

  // keep running after disable until shift and holding are empty
  assign tx_active = ctrl_reg.tx_enable_bit | tx_busy_reg;
  // a data write in the same cycle defers the load by one cycle
  assign tx_end  = tx_busy_reg && bit_tick && tx_cnt_reg == 4'h1;
  assign tx_load = tx_full_reg && !wr_data && (ctrl_reg.tx_enable_bit || tx_busy_reg)
                   && (!tx_busy_reg || tx_end);

  // holding register fill state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_hold_reg <= 8'h00;
      tx_full_reg <= 1'b0;
    end else if (wr_data) begin
      tx_hold_reg <= w_reg;
      tx_full_reg <= 1'b1;
    end else if (tx_load) begin
      tx_full_reg <= 1'b0;
    end
  end

  // shift register: start at bit 0, stop on top, lsb first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sh_reg   <= 11'h7ff;
      tx_cnt_reg  <= 4'h0;
      tx_busy_reg <= 1'b0;
    end else if (tx_load) begin
      tx_busy_reg <= 1'b1;
      if (ctrl_reg.nine_bit_select) begin
        tx_sh_reg  <= {1'b1, ctrl_reg.tx_ninth_bit, tx_hold_reg, 1'b0};
        tx_cnt_reg <= 4'hb;
      end else begin
        tx_sh_reg  <= {2'b11, tx_hold_reg, 1'b0};
        tx_cnt_reg <= 4'ha;
      end
    end else if (tx_busy_reg && bit_tick) begin
      tx_sh_reg  <= {1'b1, tx_sh_reg[10:1]};
      tx_cnt_reg <= tx_cnt_reg - 4'h1;
      if (tx_cnt_reg == 4'h1) begin
        tx_busy_reg <= 1'b0;
      end
    end
  end

  // buffer-empty: set on load, cleared by a data write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      empty_reg <= STATUS_RST[S_EMPTY];
    end else if (tx_load) begin
      empty_reg <= 1'b1;
    end else if (wr_data) begin
      empty_reg <= 1'b0;
    end
  end

  // transmit-done after a whole stop period, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_done_reg <= STATUS_RST[S_TX_DONE];
    end else if (tx_end && !tx_full_reg && !wr_data) begin
      tx_done_reg <= 1'b1;
    end else if (tx_done_ack ||
                 (wr_go && w_lane_reg && w_reg[S_TX_DONE] &&
                  aw_reg == {IDX_STATUS[ADDR_W-3:0], 2'b00})) begin
      tx_done_reg <= 1'b0;
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  rx_state_t  rx_state_reg;
  logic [4:0] smp_reg;
  logic [2:0] vote_reg;
  logic [3:0] nbit_reg;
  logic       vote_now;

  // votes taken at samples 8, 9 and 10
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vote_reg <= 3'b000;
    end else if (tick16 && (smp_reg == SMP_A - 5'h01 || smp_reg == SMP_B - 5'h01 ||
                            smp_reg == SMP_C - 5'h01)) begin
      vote_reg <= {vote_reg[1:0], line_in_i};
    end
  end
  // the vote is complete once sample 10 is in
  assign vote_now  = maj3(vote_reg);
  assign rx_finish = rx_state_reg == RX_STOP && tick16 && smp_reg == SMP_C && ctrl_reg.rx_enable_bit;
  assign ovr_now   = rx_done_reg & ~rd_data;

  // receive sequencer; disabling aborts without touching flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_reg <= RX_IDLE;
      smp_reg      <= 5'h00;
      nbit_reg     <= 4'h0;
      rx_sh_reg    <= 9'h000;
    end else if (!ctrl_reg.rx_enable_bit) begin
      rx_state_reg <= RX_IDLE;
    end else if (tick16) begin
      case (rx_state_reg)
        RX_IDLE: begin
          if (!line_in_i) begin
            rx_state_reg <= RX_START; // one low sample is sample 1
            smp_reg      <= 5'h01;
          end
        end
        RX_START: begin
          smp_reg <= (smp_reg == SMP_LAST) ? 5'h01 : smp_reg + 5'h01;
          if (smp_reg == SMP_C && vote_now) begin
            rx_state_reg <= RX_IDLE; // noise spike rejected
          end else if (smp_reg == SMP_LAST) begin
            rx_state_reg <= RX_DATA;
            nbit_reg     <= 4'h0;
          end
        end
        RX_DATA: begin
          smp_reg <= (smp_reg == SMP_LAST) ? 5'h01 : smp_reg + 5'h01;
          if (smp_reg == SMP_C) begin
            rx_sh_reg <= {vote_now, rx_sh_reg[8:1]};
            nbit_reg  <= nbit_reg + 4'h1;
          end
          if (smp_reg == SMP_LAST &&
              nbit_reg == (ctrl_reg.nine_bit_select ? BITS9 : BITS8)) begin
            rx_state_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          smp_reg <= smp_reg + 5'h01;
          if (smp_reg == SMP_C) begin
            rx_state_reg <= RX_IDLE; // hunt again after the stop vote
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // transfer to the data register; an overrun keeps the unread byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_reg <= 8'h00;
    end else if (rx_finish && !ovr_now) begin
      rx_data_reg <= ctrl_reg.nine_bit_select ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
    end
  end

  // receive-done: set wins over the clear by a data read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_done_reg <= STATUS_RST[S_RX_DONE];
    end else if (rx_finish) begin
      rx_done_reg <= 1'b1;
    end else if (rd_data) begin
      rx_done_reg <= 1'b0;
    end
  end

  // frame fault follows each stop vote
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_reg <= STATUS_RST[S_FRAME];
    end else if (rx_finish) begin
      frame_reg <= ~vote_now;
    end
  end

  // overrun is held back until the pending byte is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr_pend_reg <= 1'b0;
      ovr_vis_reg  <= STATUS_RST[S_OVR];
    end else if (rx_finish) begin
      ovr_pend_reg <= ovr_now;
      ovr_vis_reg  <= rd_data & ovr_pend_reg;
    end else if (rd_data) begin
      ovr_vis_reg  <= ovr_pend_reg;
      ovr_pend_reg <= 1'b0;
    end
  end

  // ****************************************
  // interrupt requests and pins
  // ****************************************
  assign rx_done_irq  = rx_done_reg & ctrl_reg.rx_done_irq_enable;
  assign tx_done_irq  = tx_done_reg & ctrl_reg.tx_done_irq_enable;
  assign tx_empty_irq = empty_reg & ctrl_reg.tx_empty_irq_enable;

  // transmitter owns the output pin while active
  assign line_out_o    = tx_active ? (tx_busy_reg ? tx_sh_reg[0] : 1'b1) : line_out_port_val;
  assign line_out_oe_n = tx_active ? 1'b0 : ~line_out_dir_bit;

  // receiver forces input; pull-up stays with the port bit
  assign line_in_oe_n      = ctrl_reg.rx_enable_bit ? 1'b1 : ~line_in_dir_bit;
  assign line_in_pullup_en = line_in_pullup_bit & (ctrl_reg.rx_enable_bit | ~line_in_dir_bit);

endmodule : async_serial_transceiver

// ==== core/serial_pkg.sv ====
// shared constants and types of the asynchronous serial transceiver
// Summary of operation
// - loading a character clears the lowest shift bit as start and sets the top as stop
// - in nine-bit mode the ninth transmit bit goes to shift position 9 at load
// - line sends start bit, data bits lsb first, then stop bit on baud ticks
// - after the stop bit a waiting character loads and buffer-empty sets, else stays set
// - transmit-done sets after a full stop period with no new character waiting
// - with transmit enabled the transmitter drives the output pin, overriding direction
// - receiver samples at sixteen times baud; one low idle sample starts detection
// - majority high of samples 8, 9, 10 rejects the start bit as noise
// - each data bit is the majority of samples 8, 9, 10, shifted in
// - stop bit accepted on majority high, otherwise the frame fault flag sets
// - frame fault flag clears when a received stop bit is high
// - a finished character moves to the receive data register unless an unread one is pending; every one sets rx done
// - one data address: writes reach transmit holding, reads return received data
// - in nine-bit mode received bit 9 goes to the control receive ninth bit
// - a character finishing while unread records overrun, shown after the read
// - with receive enabled the input pin is input, pull-up still from the port bit
// - reading data clears rx done; rx request while flag and enable are set
// - transmit-done clears on vector acknowledge or a one written to it
// - empty request holds while flag and enable set; data write clears the flag
// - reset sets buffer-empty; every other status bit resets to zero
// - a disabled receiver sets no flags and leaves set flags alone
// - disabling transmit finishes the shifting and waiting characters first
// - baud rate is clock over sixteen times divider plus one
package serial_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DIVIDER = 8'h09;
  localparam logic [7:0] IDX_CONTROL = 8'h0a;
  localparam logic [7:0] IDX_STATUS  = 8'h0b;
  localparam logic [7:0] IDX_DATA    = 8'h0c;
  localparam int         ADDR_W      = 8;

  // control bit positions
  localparam int C_RX_IRQ  = 7;
  localparam int C_TX_IRQ  = 6;
  localparam int C_EMP_IRQ = 5;
  localparam int C_RX_EN   = 4;
  localparam int C_TX_EN   = 3;
  localparam int C_NINE    = 2;
  localparam int C_RX_B8   = 1;
  localparam int C_TX_B8   = 0;

  // status bit positions
  localparam int S_RX_DONE = 7;
  localparam int S_TX_DONE = 6;
  localparam int S_EMPTY   = 5;
  localparam int S_FRAME   = 4;
  localparam int S_OVR     = 3;

  // reset values
  localparam logic [7:0] STATUS_RST  = 8'h20;
  localparam logic [7:0] CONTROL_RST = 8'h02;
  localparam logic [7:0] DIVIDER_RST = 8'h00;

  // oversampling and vote points
  localparam logic [3:0] OVERSAMPLE = 4'hf; // sixteen ticks, counted 0..15
  localparam logic [4:0] SMP_A      = 5'h08;
  localparam logic [4:0] SMP_B      = 5'h09;
  localparam logic [4:0] SMP_C      = 5'h0a;
  localparam logic [4:0] SMP_LAST   = 5'h10;
  localparam logic [3:0] BITS8      = 4'h8;
  localparam logic [3:0] BITS9      = 4'h9;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic rx_done_irq_enable;
    logic tx_done_irq_enable;
    logic tx_empty_irq_enable;
    logic rx_enable_bit;
    logic tx_enable_bit;
    logic nine_bit_select;
    logic rx_ninth_bit;
    logic tx_ninth_bit;
  } ctrl_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } rx_state_t;

endpackage : serial_pkg

// ==== tb/async_serial_transceiver_assertions.sv ====
// port checker of the serial transceiver
`timescale 1ns/1ns
module async_serial_transceiver_assertions
  import serial_pkg::*;
(
  // clock, reset, bus
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic [serial_pkg::ADDR_W-1:0] araddr,
  input wire logic                      arvalid,
  input wire logic                      arready,
  input wire logic [31:0]               rdata,
  input wire logic [1:0]                rresp,
  input wire logic                      rvalid,
  input wire logic                      rready,
  input wire logic                      awvalid,
  input wire logic                      awready,
  input wire logic                      wvalid,
  input wire logic                      wready,
  input wire logic [1:0]                bresp,
  input wire logic                      bvalid,
  input wire logic                      bready,
  // requests and pins
  input wire logic                      rx_done_irq,
  input wire logic                      tx_done_irq,
  input wire logic                      tx_empty_irq,
  input wire logic                      line_out_dir_bit,
  input wire logic                      line_out_oe_n,
  input wire logic                      line_in_dir_bit,
  input wire logic                      line_in_oe_n,
  input wire logic                      line_in_pullup_bit,
  input wire logic                      line_in_pullup_en
);
  // ****************
  // bus and pin checks
  // ****************
  default clocking @(posedge aclk); endclocking

  a_bresp_holds: assert property (disable iff (!aresetn) bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (disable iff (!aresetn) rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (disable iff (!aresetn) arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (disable iff (!aresetn)
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write not answered");
  a_unmapped_read: assert property (disable iff (!aresetn)
    arvalid && arready && araddr == 8'h00 |=> rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  a_reset_quiet: assert property (!aresetn |=> !bvalid && !rvalid && !rx_done_irq && !tx_done_irq
    && !tx_empty_irq)
    else $error("outputs active after reset");
  a_out_owned: assert property (disable iff (!aresetn) line_out_dir_bit |-> !line_out_oe_n)
    else $error("output pin not driven");
  a_in_pullup: assert property (disable iff (!aresetn)
    line_in_dir_bit && line_in_oe_n |-> line_in_pullup_en == line_in_pullup_bit)
    else $error("pull-up not from port bit");
endmodule : async_serial_transceiver_assertions

// ==== tb/serial_station.sv ====
// remote serial station model facing the transceiver pins
`timescale 1ns/1ns
module serial_station (
  // clock and line pins
  input  wire logic clk,
  input  wire logic tx_line,
  input  wire logic tx_drive_n,
  input  wire logic nine,
  output logic      rx_line
);
  // ****************
  // sender and decoder
  // ****************
  logic [9:0] rxq[$]; // decoded characters, stop bit on top
  initial rx_line = 1'b1;

  // one bit is sixteen clocks at divider zero; line idles high
  task automatic send(input logic [8:0] d, input logic stop, input int nb);
    for (int i = -1; i <= nb; i++) begin
      rx_line <= (i < 0) ? 1'b0 : (i == nb) ? stop : d[i];
      repeat (16) @(posedge clk);
    end
    rx_line <= 1'b1;
    repeat (24) @(posedge clk);
  endtask : send

  // short low pulse, too brief to pass the start vote
  task automatic spike;
    rx_line <= 1'b0;
    repeat (3) @(posedge clk);
    rx_line <= 1'b1;
    repeat (40) @(posedge clk);
  endtask : spike

  // each bit is sampled 16 clocks after the one before, from the start edge
  always begin : decode
    logic [9:0] c;
    @(posedge clk);
    if (!tx_drive_n && !tx_line) begin
      c = 10'h000;
      for (int i = 0; i <= 8 + nine; i++) begin
        repeat (16) @(posedge clk);
        c[(i == 8 + nine) ? 9 : i] = tx_line;
      end
      rxq.push_back(c);
    end
  end
endmodule : serial_station

// ==== tb/async_serial_transceiver_tb.sv ====
// self-checking bench of the serial transceiver
`timescale 1ns/1ns
module async_serial_transceiver_tb;
  import serial_pkg::*;
  // ****************
  // bench
  // ****************
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic rx_done_irq, tx_done_irq, tx_empty_irq, tx_done_ack, line_out_port_val, line_out_dir_bit, nine;
  logic line_out_o, line_out_oe_n, line_in_i, line_in_dir_bit, line_in_pullup_bit, line_in_oe_n, line_in_pullup_en;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [9:0]  exq[$];
  int          mismatches, comparisons;
  localparam logic [7:0] A_DIV = IDX_DIVIDER << 2;
  localparam logic [7:0] A_CT  = IDX_CONTROL << 2;
  localparam logic [7:0] A_ST  = IDX_STATUS << 2;
  localparam logic [7:0] A_DT  = IDX_DATA << 2;

  async_serial_transceiver dut_u (.*);
  serial_station st_u (.clk(aclk), .tx_line(line_out_o), .tx_drive_n(line_out_oe_n), .nine(nine),
    .rx_line(line_in_i));

  always #50 aclk = ~aclk;

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  function automatic logic [7:0] st(input logic rx, tx, em, fe, ov);
    return {rx, tx, em, fe, ov, 3'b000};
  endfunction : st

  // write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw = 1'b0, w = 1'b0, b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      b = aw && w && bvalid;
      if (b) chk("bresp", bresp, er);
      aw |= awready;
      w |= wready;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic ar = 1'b0, got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(negedge aclk);
      got = ar && rvalid;
      if (got) chk("rdata", rdata, {24'h0, e});
      if (got) chk("rresp", rresp, er);
      ar |= arready;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      if (got) rready <= 1'b0;
    end
  endtask : rd

  // waits for n decoded characters and the last stop period
  task automatic drain(input int n);
    for (int t = 0; t < 3000 && st_u.rxq.size() < n; t++) @(posedge aclk);
    repeat (40) @(posedge aclk);
    while (exq.size() > 0) chk("tx char", st_u.rxq.pop_front(), exq.pop_front());
  endtask : drain

  task automatic report_and_stop;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    logic [8:0] d, d2;
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tx_done_ack, nine} = '0;
    {awaddr, araddr, wdata, line_out_dir_bit, line_in_dir_bit} = '0;
    {wstrb, line_out_port_val, line_in_pullup_bit} = '1;
    mismatches = 0;
    comparisons = 0;
    void'($urandom(11934));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, refused addresses, pin ownership
    rd(A_ST, st(0, 0, 1, 0, 0), RESP_OKAY);
    rd(A_CT, 8'h02, RESP_OKAY);
    rd(8'h00, 8'h00, RESP_SLVERR);
    wr(8'h00, 8'h55, RESP_SLVERR);
    chk("line_out_oe_n", line_out_oe_n, 1'b1);
    wr(A_DIV, 8'h00, RESP_OKAY);
    wr(A_CT, 8'hf8, RESP_OKAY);
    line_in_dir_bit <= 1'b1;
    @(negedge aclk);
    chk("line_out_oe_n", line_out_oe_n, 1'b0);
    chk("line_in_oe_n", line_in_oe_n, 1'b1);
    chk("tx_empty_irq", tx_empty_irq, 1'b1);
    // characters back to back, the second waits in the holding register
    for (int k = 0; k < 4; k++) begin
      d = 9'($urandom);
      exq.push_back({2'b10, d[7:0]});
      wr(A_DT, d[7:0], RESP_OKAY);
      if (k == 1) chk("tx_empty_irq", tx_empty_irq, 1'b0);
      while (!tx_empty_irq) @(posedge aclk);
    end
    drain(4);
    rd(A_ST, st(0, 1, 1, 0, 0), RESP_OKAY);
    tx_done_ack <= 1'b1;
    @(posedge aclk);
    tx_done_ack <= 1'b0;
    @(negedge aclk);
    chk("tx_done_irq", tx_done_irq, 1'b0);
    // nine-bit character, ninth bit set before the data write
    wr(A_CT, 8'hfd, RESP_OKAY);
    nine <= 1'b1;
    d = 9'($urandom);
    exq.push_back({2'b11, d[7:0]});
    wr(A_DT, d[7:0], RESP_OKAY);
    drain(1);
    wr(A_ST, 8'h40, RESP_OKAY);
    rd(A_ST, st(0, 0, 1, 0, 0), RESP_OKAY);
    wr(A_CT, 8'hf8, RESP_OKAY);
    nine <= 1'b0;
    // good, broken and good stop bits
    for (int k = 0; k < 3; k++) begin
      d = 9'($urandom);
      line_in_pullup_bit <= 1'($urandom);
      st_u.send({1'b0, d[7:0]}, k != 1, 8);
      chk("rx_done_irq", rx_done_irq, 1'b1);
      rd(A_ST, st(1, 0, 1, k == 1, 0), RESP_OKAY);
      rd(A_DT, d[7:0], RESP_OKAY);
      chk("rx_done_irq", rx_done_irq, 1'b0);
    end
    // overrun, then a spike, then a fresh character
    d = 9'($urandom);
    d2 = 9'($urandom);
    st_u.send({1'b0, d[7:0]}, 1'b1, 8);
    st_u.send({1'b0, d2[7:0]}, 1'b1, 8);
    rd(A_DT, d[7:0], RESP_OKAY);
    rd(A_ST, st(0, 0, 1, 0, 1), RESP_OKAY);
    st_u.spike();
    chk("rx_done_irq", rx_done_irq, 1'b0);
    st_u.send({1'b0, d2[7:0]}, 1'b1, 8);
    rd(A_ST, st(1, 0, 1, 0, 0), RESP_OKAY);
    rd(A_DT, d2[7:0], RESP_OKAY);
    // nine-bit reception with a cleared ninth bit
    wr(A_CT, 8'hfc, RESP_OKAY);
    st_u.send({1'b0, d[7:0]}, 1'b1, 9);
    rd(A_CT, 8'hfc, RESP_OKAY);
    rd(A_DT, d[7:0], RESP_OKAY);
    // receiver off: a full frame leaves the flags alone
    wr(A_CT, 8'he8, RESP_OKAY);
    line_out_dir_bit <= 1'b1;
    st_u.send({1'b0, d[7:0]}, 1'b0, 8);
    rd(A_ST, st(0, 0, 1, 0, 0), RESP_OKAY);
    report_and_stop();
  end
endmodule : async_serial_transceiver_tb

bind async_serial_transceiver async_serial_transceiver_assertions chk_u (.*);
